/* tb/tb.sv */
// self-checking bench for the user register file of the 8-bit core
// assumes curf_pkg is compiled first; the bench drives req and addrReq directly
`timescale 1ns/100ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
   // one ordinary case: request and what it should leave behind
   typedef struct packed {
      curf_pkg::curf_op_type  op;
      curf_pkg::curf_sel_type dst;
      curf_pkg::curf_sel_type src;
      logic [7:0]             data;
      logic                   refused;
      logic [15:0]            val;
      logic                   chkN;
      logic                   negVal;
   } curf_tb_row_type;

   localparam int NROWS = 14;
   localparam curf_tb_row_type ROWS [NROWS] = '{
      '{curf_pkg::OP_LOAD, curf_pkg::SEL_ACC,  curf_pkg::SEL_ACC,  8'h80, 1'b0, 16'h0080, 1'b1, 1'b1},
      '{curf_pkg::OP_XFER, curf_pkg::SEL_BASE, curf_pkg::SEL_ACC,  8'h00, 1'b0, 16'h0080, 1'b0, 1'b0},
      '{curf_pkg::OP_LOAD, curf_pkg::SEL_BASE, curf_pkg::SEL_ACC,  8'h33, 1'b1, 16'h0080, 1'b0, 1'b0},
      '{curf_pkg::OP_ADD,  curf_pkg::SEL_IDX1, curf_pkg::SEL_ACC,  8'h01, 1'b1, 16'h0000, 1'b0, 1'b0},
      '{curf_pkg::OP_LOAD, curf_pkg::SEL_IDX1, curf_pkg::SEL_ACC,  8'h10, 1'b0, 16'h0010, 1'b0, 1'b0},
      '{curf_pkg::OP_INC,  curf_pkg::SEL_IDX1, curf_pkg::SEL_IDX1, 8'h00, 1'b0, 16'h0011, 1'b0, 1'b0},
      '{curf_pkg::OP_DEC,  curf_pkg::SEL_IDX1, curf_pkg::SEL_IDX1, 8'h00, 1'b0, 16'h0010, 1'b0, 1'b0},
      '{curf_pkg::OP_AND,  curf_pkg::SEL_IDX2, curf_pkg::SEL_ACC,  8'h0f, 1'b1, 16'h0000, 1'b0, 1'b0},
      '{curf_pkg::OP_XFER, curf_pkg::SEL_BASE, curf_pkg::SEL_IDX1, 8'h00, 1'b1, 16'h0080, 1'b0, 1'b0},
      '{curf_pkg::OP_LOAD, curf_pkg::SEL_ACC,  curf_pkg::SEL_ACC,  8'h05, 1'b0, 16'h0005, 1'b1, 1'b0},
      // accumulator arithmetic: carry is clear here, shift sets it, rotate brings it back in
      '{curf_pkg::OP_ADD,  curf_pkg::SEL_ACC,  curf_pkg::SEL_ACC,  8'h7b, 1'b0, 16'h0080, 1'b1, 1'b1},
      '{curf_pkg::OP_SHL,  curf_pkg::SEL_ACC,  curf_pkg::SEL_ACC,  8'h00, 1'b0, 16'h0000, 1'b1, 1'b0},
      '{curf_pkg::OP_ROL,  curf_pkg::SEL_ACC,  curf_pkg::SEL_ACC,  8'h00, 1'b0, 16'h0001, 1'b1, 1'b0},
      '{curf_pkg::OP_XOR,  curf_pkg::SEL_ACC,  curf_pkg::SEL_ACC,  8'h01, 1'b0, 16'h0000, 1'b1, 1'b0}
   };

   logic                    sys_clk = 1'b0;
   logic                    rst     = 1'b1;
   curf_pkg::curf_req_type  req     = '0;
   curf_pkg::curf_addr_type addrReq = '0;
   logic [7:0]              accOut, idx1Out, idx2Out, idx3Out, baseOut, statusOut;
   logic [15:0]             stackOut, pcOut, shortAddr;
   logic                    addrRefused, opRefused, refSeen;
   int                      num_errors = 0;
   int                      n_compared = 0;

   // 200 MHz core clock
   always #2.5 sys_clk = ~sys_clk;

   curf_register_file u_curf_register_file (
      .sys_clk    (sys_clk),
      .rst        (rst),
      .req        (req),
      .addrReq    (addrReq),
      .accOut     (accOut),
      .idx1Out    (idx1Out),
      .idx2Out    (idx2Out),
      .idx3Out    (idx3Out),
      .baseOut    (baseOut),
      .statusOut  (statusOut),
      .stackOut   (stackOut),
      .pcOut      (pcOut),
      .shortAddr  (shortAddr),
      .addrRefused(addrRefused),
      .opRefused  (opRefused)
   );

   // register value by selector, widened so one compare fits all
   function automatic logic [15:0] regv(curf_pkg::curf_sel_type s);
      case (s)
         curf_pkg::SEL_ACC:    return {8'h00, accOut};
         curf_pkg::SEL_IDX1:   return {8'h00, idx1Out};
         curf_pkg::SEL_IDX2:   return {8'h00, idx2Out};
         curf_pkg::SEL_IDX3:   return {8'h00, idx3Out};
         curf_pkg::SEL_BASE:   return {8'h00, baseOut};
         curf_pkg::SEL_STATUS: return {8'h00, statusOut};
         curf_pkg::SEL_STACK:  return stackOut;
         default:              return pcOut;
      endcase
   endfunction

   function automatic curf_pkg::curf_req_type mk(curf_pkg::curf_op_type op, curf_pkg::curf_sel_type dst,
                                                 curf_pkg::curf_sel_type src, logic [7:0] data);
      curf_pkg::curf_req_type r;
      r      = '0;
      r.op   = op;
      r.dst  = dst;
      r.src  = src;
      r.data = data;
      return r;
   endfunction

   // one request held for one cycle, refusal sampled mid-cycle, result read a cycle later
   task automatic issue(input curf_pkg::curf_req_type r);
      @(posedge sys_clk) req <= r;
      @(negedge sys_clk) refSeen = opRefused;
      @(posedge sys_clk) req <= '0;
      @(negedge sys_clk);
   endtask

   task automatic do_reset(input int n);
      @(posedge sys_clk) rst <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic summarize();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // address modes: mode, whether refused, expected short address (base 80, idx1 10, offset f8)
   curf_pkg::curf_ix_type modes [6] = '{curf_pkg::IX_NONE, curf_pkg::IX_PRE_IDX1, curf_pkg::IX_POST_IDX1,
                                         curf_pkg::IX_POST_IDX2, curf_pkg::IX_POST_IDX3, curf_pkg::IX_POST_ACC};
   logic        mRef [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
   logic [15:0] mAdr [6] = '{16'h80f8, 16'h8008, 16'h0000, 16'h80f8, 16'h80f8, 16'h0000};

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #20000;
      num_errors++;
      summarize();
   end

   initial begin
      curf_pkg::curf_req_type r;
      do_reset(4);
      // reset state
      `CHK(idx3Out, 8'h00)
      `CHK(baseOut, 8'h00)
      `CHK(stackOut, 16'h01ff)
      `CHK({statusOut[curf_pkg::ST_EXT], statusOut[curf_pkg::ST_IRQ]}, 2'b11)
      `CHK({accOut, idx1Out, idx2Out, pcOut}, 40'h0)
      // ordinary cases
      for (int i = 0; i < NROWS; i++) begin
         issue(mk(ROWS[i].op, ROWS[i].dst, ROWS[i].src, ROWS[i].data));
         `CHK(refSeen, ROWS[i].refused)
         if (!ROWS[i].refused) `CHK(regv(ROWS[i].dst), ROWS[i].val)
         if (ROWS[i].chkN) `CHK(statusOut[curf_pkg::ST_NEG], ROWS[i].negVal)
      end
      `CHK(baseOut, 8'h80)
      `CHK(statusOut[curf_pkg::ST_ZERO], 1'b1)
      // short addresses, with a low-byte wrap in the pre-indexed case
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk) addrReq <= '{mode: modes[i], offset: 8'hf8};
         @(negedge sys_clk);
         `CHK(addrRefused, mRef[i])
         if (!mRef[i]) `CHK(shortAddr, mAdr[i])
      end
      // stack: page wrap with extend set, full carry with extend clear
      issue(mk(curf_pkg::OP_LOAD, curf_pkg::SEL_IDX1, curf_pkg::SEL_ACC, 8'hff));
      issue(mk(curf_pkg::OP_XFER, curf_pkg::SEL_STACK, curf_pkg::SEL_IDX1, 8'h00));
      `CHK(stackOut, 16'h01ff)
      r = '0;
      r.spInc = 1'b1;
      issue(r);
      `CHK(stackOut, 16'h0100)
      r = '0;
      r.flagClr = 1'b1;
      r.flagBit = 3'(curf_pkg::ST_EXT);
      issue(r);
      `CHK(statusOut[curf_pkg::ST_EXT], 1'b0)
      issue(mk(curf_pkg::OP_XFER, curf_pkg::SEL_STACK, curf_pkg::SEL_IDX1, 8'h00));
      r = '0;
      r.spInc = 1'b1;
      issue(r);
      `CHK(stackOut, 16'h0200)
      // explicit flag set and clear
      r = '0;
      r.flagSet = 1'b1;
      r.flagBit = 3'(curf_pkg::ST_DEC);
      issue(r);
      `CHK(statusOut[curf_pkg::ST_DEC], 1'b1)
      r.flagSet = 1'b0;
      r.flagClr = 1'b1;
      issue(r);
      `CHK(statusOut[curf_pkg::ST_DEC], 1'b0)
      // program counter increments and loads across its full width
      r = '0;
      r.pcLoad = 1'b1;
      r.pcData = 16'h12ff;
      issue(r);
      r = '0;
      r.pcInc = 1'b1;
      issue(r);
      `CHK(pcOut, 16'h1300)
      // reset in mid-run clears third index and base page again
      issue(mk(curf_pkg::OP_LOAD, curf_pkg::SEL_IDX3, curf_pkg::SEL_ACC, 8'h55));
      `CHK(idx3Out, 8'h55)
      do_reset(1);
      `CHK({idx3Out, baseOut}, 16'h0000)
      `CHK(stackOut, 16'h01ff)
      `CHK(statusOut[curf_pkg::ST_EXT], 1'b1)
      summarize();
   end
endmodule

/* verilog/curf_pkg.sv */
// package for the user register file of the 8-bit core
// assumes one synchronous clock domain and a decoder that issues one operation per cycle
package curf_pkg;

   localparam int DATA_W      = 8;
   localparam int WORD_W      = 16;
   localparam int REG_COUNT   = 8;

   // reset values
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [7:0]  IDX_RST     = 8'h00;
   localparam logic [7:0]  BASE_RST    = 8'h00;
   localparam logic [7:0]  STACK_PAGE  = 8'h01;
   localparam logic [7:0]  STACK_LOW   = 8'hff;
   localparam logic [15:0] PC_RST      = 16'h0000;
   localparam logic [7:0]  STATUS_RST  = 8'h24;

   // status bit positions
   localparam int ST_NEG   = 7;
   localparam int ST_OVF   = 6;
   localparam int ST_EXT   = 5;
   localparam int ST_BRK   = 4;
   localparam int ST_DEC   = 3;
   localparam int ST_IRQ   = 2;
   localparam int ST_ZERO  = 1;
   localparam int ST_CARRY = 0;

   // register selectors
   typedef enum logic [2:0] {
      SEL_ACC, SEL_IDX1, SEL_IDX2, SEL_IDX3, SEL_BASE, SEL_STATUS, SEL_STACK, SEL_PC
   } curf_sel_type;

   // operations the decoder may request
   typedef enum logic [3:0] {
      OP_NONE, OP_ADD, OP_SUB, OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_NEG,
      OP_AND, OP_OR, OP_XOR, OP_LOAD, OP_INC, OP_DEC, OP_CMP, OP_XFER
   } curf_op_type;

   // addressing index choices
   typedef enum logic [2:0] {
      IX_NONE, IX_PRE_IDX1, IX_POST_IDX1, IX_POST_IDX2, IX_POST_IDX3, IX_POST_ACC
   } curf_ix_type;

   // one request from the decoder
   typedef struct packed {
      curf_op_type  op;
      curf_sel_type dst;
      curf_sel_type src;
      logic [7:0]   data;
      logic         flagSet;
      logic         flagClr;
      logic [2:0]   flagBit;
      logic         pcInc;
      logic         pcLoad;
      logic [15:0]  pcData;
      logic         spInc;
      logic         spDec;
   } curf_req_type;

   // short-address request
   typedef struct packed {
      curf_ix_type mode;
      logic [7:0]  offset;
   } curf_addr_type;

endpackage

/* verilog/curf_register_file.sv */
// user-visible register set of the 8-bit core with base-page address forming
// assumes decoder requests are synchronous to sys_clk and valid for one cycle
`timescale 1ns/100ps

// Notes on behaviour
// - eight user registers: accumulator, three index, base page, status, stack, counter.
// - arithmetic and boolean operations act only on the accumulator.
// - the accumulator is never accepted as an address index.
// - index registers only increment, decrement, compare or load/transfer.
// - first index only for pre-indexed indirect, refused for post-indexed indirect.
// - second index serves as post-indexed indirect offset.
// - third index clears at reset.
// - third index serves as post-indexed indirect offset.
// - base page is loaded only by transfer from the accumulator.
// - base page clears at reset, so short addresses start at page zero.
// - status is eight flags, some from results, some by explicit set or clear.
// - negative flag follows bit seven of each result, except a load or transfer to the stack.
// - short address takes offset, plus first index when pre-indexed, as low byte, base page as high byte.
// - extend flag set gives 8-bit page stack, clear gives 16-bit stack.
// - reset puts stack in byte mode on page one, sets extend and irq disable.
module curf_register_file (
   input  wire logic                   sys_clk,    // core clock
   input  wire logic                   rst,        // synchronous reset, active high
   input  wire curf_pkg::curf_req_type req,        // operation request
   input  wire curf_pkg::curf_addr_type addrReq,   // short-address request
   output logic [7:0]                  accOut,     // accumulator
   output logic [7:0]                  idx1Out,    // first index
   output logic [7:0]                  idx2Out,    // second index
   output logic [7:0]                  idx3Out,    // third index
   output logic [7:0]                  baseOut,    // base page
   output logic [7:0]                  statusOut,  // status flags
   output logic [15:0]                 stackOut,   // stack pointer
   output logic [15:0]                 pcOut,      // program counter
   output logic [15:0]                 shortAddr,  // formed short address
   output logic                        addrRefused,// index choice not allowed
   output logic                        opRefused   // operation not allowed on target
);

   logic [7:0]  acc_reg, acc_next;
   logic [7:0]  idx_reg [3];
   logic [7:0]  idx_next [3];
   logic [7:0]  base_reg, base_next;
   logic [7:0]  status_reg, status_next;
   logic [15:0] stack_reg, stack_next;
   logic [15:0] pc_reg, pc_next;

   // source value selection, used by transfers and the step unit
   function automatic logic [7:0] pick(input curf_pkg::curf_sel_type s, input logic [7:0] a,
                                       input logic [7:0] x1, input logic [7:0] x2,
                                       input logic [7:0] x3, input logic [7:0] b,
                                       input logic [7:0] p, input logic [15:0] sp);
      case (s)
         curf_pkg::SEL_ACC:    pick = a;
         curf_pkg::SEL_IDX1:   pick = x1;
         curf_pkg::SEL_IDX2:   pick = x2;
         curf_pkg::SEL_IDX3:   pick = x3;
         curf_pkg::SEL_BASE:   pick = b;
         curf_pkg::SEL_STATUS: pick = p;
         curf_pkg::SEL_STACK:  pick = sp[7:0];
         default:              pick = 8'h00;
      endcase
   endfunction

   wire logic [7:0] srcVal = pick(req.src, acc_reg, idx_reg[0], idx_reg[1], idx_reg[2],
                                  base_reg, status_reg, stack_reg);
   wire logic [7:0] opnd = (req.op == curf_pkg::OP_XFER) ? srcVal : req.data;

   // operation class decode
   wire logic isAlu  = req.op inside {curf_pkg::OP_ADD, curf_pkg::OP_SUB, curf_pkg::OP_SHL,
                       curf_pkg::OP_SHR, curf_pkg::OP_ROL, curf_pkg::OP_ROR, curf_pkg::OP_NEG,
                       curf_pkg::OP_AND, curf_pkg::OP_OR, curf_pkg::OP_XOR};
   wire logic isStep = req.op inside {curf_pkg::OP_INC, curf_pkg::OP_DEC, curf_pkg::OP_CMP};
   wire logic dstIdx = req.dst inside {curf_pkg::SEL_IDX1, curf_pkg::SEL_IDX2, curf_pkg::SEL_IDX3};
   wire logic dstAcc = (req.dst == curf_pkg::SEL_ACC);
   // base page accepts only a transfer whose source is the accumulator
   wire logic baseBad = (req.dst == curf_pkg::SEL_BASE) && (req.op != curf_pkg::OP_NONE) &&
                        !(req.op == curf_pkg::OP_XFER && req.src == curf_pkg::SEL_ACC);
   assign opRefused = (isAlu && !dstAcc)
                    || (isStep && !(dstIdx || dstAcc))
                    || baseBad;

   // alu result with carry in bit 8
   logic [8:0] aluRes;
   logic       carryIn;
   logic [8:0] stepRes;
   logic [7:0] stepSrc;
   assign carryIn = status_reg[curf_pkg::ST_CARRY];
   always_comb begin
      case (req.op)
         curf_pkg::OP_ADD: aluRes = {1'b0, acc_reg} + {1'b0, req.data} + {8'h00, carryIn};
         curf_pkg::OP_SUB: aluRes = {1'b0, acc_reg} + {1'b0, ~req.data} + {8'h00, carryIn};
         curf_pkg::OP_SHL: aluRes = {acc_reg, 1'b0};
         curf_pkg::OP_SHR: aluRes = {acc_reg[0], 1'b0, acc_reg[7:1]};
         curf_pkg::OP_ROL: aluRes = {acc_reg, carryIn};
         curf_pkg::OP_ROR: aluRes = {acc_reg[0], carryIn, acc_reg[7:1]};
         curf_pkg::OP_NEG: aluRes = {1'b0, 8'(-acc_reg)};
         curf_pkg::OP_AND: aluRes = {carryIn, acc_reg & req.data};
         curf_pkg::OP_OR:  aluRes = {carryIn, acc_reg | req.data};
         curf_pkg::OP_XOR: aluRes = {carryIn, acc_reg ^ req.data};
         default:          aluRes = {carryIn, acc_reg};
      endcase
   end

   // step unit serves index registers and the accumulator
   assign stepSrc = pick(req.dst, acc_reg, idx_reg[0], idx_reg[1], idx_reg[2],
                         base_reg, status_reg, stack_reg);
   always_comb begin
      case (req.op)
         curf_pkg::OP_INC: stepRes = {carryIn, 8'(stepSrc + 8'h01)};
         curf_pkg::OP_DEC: stepRes = {carryIn, 8'(stepSrc - 8'h01)};
         curf_pkg::OP_CMP: stepRes = {1'b0, stepSrc} + {1'b0, ~req.data} + 9'h001;
         default:          stepRes = {carryIn, stepSrc};
      endcase
   end

   // next state of the data registers
   wire logic writeOk = !opRefused && req.op != curf_pkg::OP_NONE;
   logic [7:0] result;
   logic       resValid;
   always_comb begin
      acc_next    = acc_reg;
      base_next   = base_reg;
      status_next = status_reg;
      for (int i = 0; i < 3; i++) begin
         idx_next[i] = idx_reg[i];
      end
      result   = 8'h00;
      resValid = 1'b0;
      if (writeOk) begin
         if (isAlu) begin
            result = aluRes[7:0];
            acc_next = aluRes[7:0];
            status_next[curf_pkg::ST_CARRY] = aluRes[8];
         end else if (isStep) begin
            result = stepRes[7:0];
            if (req.op == curf_pkg::OP_CMP) begin
               status_next[curf_pkg::ST_CARRY] = stepRes[8];
            end else if (dstAcc) begin
               acc_next = stepRes[7:0];
            end else begin
               idx_next[2'(req.dst - curf_pkg::SEL_IDX1)] = stepRes[7:0];
            end
         end else if (req.op inside {curf_pkg::OP_LOAD, curf_pkg::OP_XFER}) begin
            result = opnd;
            case (req.dst)
               curf_pkg::SEL_ACC:    acc_next = opnd;
               curf_pkg::SEL_IDX1:   idx_next[0] = opnd;
               curf_pkg::SEL_IDX2:   idx_next[1] = opnd;
               curf_pkg::SEL_IDX3:   idx_next[2] = opnd;
               curf_pkg::SEL_BASE:   base_next = opnd;
               curf_pkg::SEL_STATUS: status_next = opnd;
               default:              ;
            endcase
         end
         resValid = (req.dst != curf_pkg::SEL_STATUS) && (req.dst != curf_pkg::SEL_STACK);
      end
      // result flags, then explicit flag set or clear
      if (resValid) begin
         status_next[curf_pkg::ST_NEG]  = result[7];
         status_next[curf_pkg::ST_ZERO] = (result == 8'h00);
      end
      if (req.flagSet) begin
         status_next[req.flagBit] = 1'b1;
      end else if (req.flagClr) begin
         status_next[req.flagBit] = 1'b0;
      end
   end

   // stack pointer: extend-disable bit keeps the high byte as a fixed page
   wire logic byteMode = status_reg[curf_pkg::ST_EXT];
   wire logic [15:0] spUp = byteMode ? {stack_reg[15:8], 8'(stack_reg[7:0] + 8'h01)}
                                     : 16'(stack_reg + 16'h0001);
   wire logic [15:0] spDn = byteMode ? {stack_reg[15:8], 8'(stack_reg[7:0] - 8'h01)}
                                     : 16'(stack_reg - 16'h0001);
   wire logic toStack = req.op == curf_pkg::OP_XFER && req.dst == curf_pkg::SEL_STACK;
   always_comb begin
      stack_next = stack_reg;
      if (toStack && req.src == curf_pkg::SEL_IDX1) begin
         stack_next[7:0] = idx_reg[0];           // copy_index_to_stack_low
      end else if (toStack && req.src == curf_pkg::SEL_IDX2) begin
         stack_next[15:8] = idx_reg[1];          // copy_index_to_stack_high
      end else if (req.spInc) begin
         stack_next = spUp;
      end else if (req.spDec) begin
         stack_next = spDn;
      end
   end

   // program counter counts up or loads from a vector or jump target
   assign pc_next = req.pcLoad ? req.pcData : (req.pcInc ? 16'(pc_reg + 16'h0001) : pc_reg);

   // register update; reset clears index three and base, stack to page one
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_reg    <= curf_pkg::ACC_RST;
         idx_reg[0] <= curf_pkg::IDX_RST;
         idx_reg[1] <= curf_pkg::IDX_RST;
         idx_reg[2] <= curf_pkg::IDX_RST;
         base_reg   <= curf_pkg::BASE_RST;
         status_reg <= curf_pkg::STATUS_RST;
         stack_reg  <= {curf_pkg::STACK_PAGE, curf_pkg::STACK_LOW};
         pc_reg     <= curf_pkg::PC_RST;
      end else begin
         acc_reg    <= acc_next;
         idx_reg    <= idx_next;
         base_reg   <= base_next;
         status_reg <= status_next;
         stack_reg  <= stack_next;
         pc_reg     <= pc_next;
      end
   end

   // short address: offset plus first index when pre-indexed, page from base register
   logic [7:0] ixVal;
   always_comb begin
      case (addrReq.mode)
         curf_pkg::IX_PRE_IDX1:  ixVal = idx_reg[0];
         curf_pkg::IX_POST_IDX2: ixVal = idx_reg[1];
         curf_pkg::IX_POST_IDX3: ixVal = idx_reg[2];
         default:                ixVal = 8'h00;
      endcase
   end
   // the accumulator and post-indexed first index are no legal index choice
   assign addrRefused = addrReq.mode inside {curf_pkg::IX_POST_IDX1, curf_pkg::IX_POST_ACC};
   // post-indexed modes add the index after the pointer fetch, outside this block
   wire logic preAdd = addrReq.mode == curf_pkg::IX_PRE_IDX1;
   assign shortAddr = {base_reg, 8'(addrReq.offset + (preAdd ? ixVal : 8'h00))};

   // outputs come straight from the registers
   assign accOut    = acc_reg;
   assign idx1Out   = idx_reg[0];
   assign idx2Out   = idx_reg[1];
   assign idx3Out   = idx_reg[2];
   assign baseOut   = base_reg;
   assign statusOut = status_reg;
   assign stackOut  = stack_reg;
   assign pcOut     = pc_reg;

   // checks
   a_base_only_acc: assert property (@(posedge sys_clk) disable iff (rst)
      (!$past(rst) && base_reg != $past(base_reg)) |-> ($past(req.op) == curf_pkg::OP_XFER &&
      $past(req.src) == curf_pkg::SEL_ACC && base_reg == $past(acc_reg)))
      else $error("base page changed without accumulator transfer");
   // rst |=> avoids a $past look before the first edge, where rst has no history
   a_reset_values: assert property (@(posedge sys_clk) rst |=>
      (stack_reg == 16'h01ff && status_reg[curf_pkg::ST_EXT] && status_reg[curf_pkg::ST_IRQ]))
      else $error("stack or status wrong after reset");
   a_reset_clears: assert property (@(posedge sys_clk) rst |=>
      (idx_reg[2] == 8'h00 && base_reg == 8'h00)) else $error("index three or base not cleared");
   a_neg_follows: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(resValid) && !$past(req.flagSet) && !$past(req.flagClr)) |->
      status_reg[curf_pkg::ST_NEG] == $past(result[7])) else $error("negative flag wrong");
   a_alu_acc_only: assert property (@(posedge sys_clk) disable iff (rst)
      (isAlu && !dstAcc) |=> (idx_reg[0] == $past(idx_reg[0]) && idx_reg[1] == $past(idx_reg[1]) &&
      idx_reg[2] == $past(idx_reg[2]) && acc_reg == $past(acc_reg)))
      else $error("alu wrote non-accumulator");
   a_short_page: assert property (@(posedge sys_clk) disable iff (rst)
      shortAddr[15:8] == base_reg) else $error("short address page not from base");
   a_acc_no_index: assert property (@(posedge sys_clk) disable iff (rst)
      (addrReq.mode == curf_pkg::IX_POST_ACC) |-> addrRefused) else $error("accumulator used as index");
   a_byte_stack: assert property (@(posedge sys_clk) disable iff (rst)
      (byteMode && (req.spInc || req.spDec) && !toStack) |=> stack_reg[15:8] == $past(stack_reg[15:8]))
      else $error("byte-mode stack left its page");

endmodule
